//--- rtl/p5pwm_top.v
// five channel 16-bit pwm generator with axi4-lite registers
//
// Contract
// - one shared 16-bit counter clears on reaching the period and flags it.
// - a channel flags a match whenever the counter equals its duty.
// - new period and duty values take effect from the next period.
// - one output period is the period value plus one pwm clocks.
// - each duty portion lasts as many pwm clocks as the duty value, capped at the whole period.
// - control bit 7 enables the generator and resets to zero.
// - control bits 2 to 0 divide the system clock by 2 to that power.
// - control bits 6 to 3 read as zero.
// - the counter is readable and writable as a low and high byte.
`timescale 1ns/10ps
`include "p5pwm_defs.vh"
module p5pwm_top (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // axi4-lite write address
  input wire [7:0] awaddr_i,
  input wire awvalid_i,
  output wire awready_o,
  // axi4-lite write data
  input wire [31:0] wdata_i,
  input wire [3:0] wstrb_i,
  input wire wvalid_i,
  output wire wready_o,
  // axi4-lite write response
  output wire [1:0] bresp_o,
  output wire bvalid_o,
  input wire bready_i,
  // axi4-lite read address
  input wire [7:0] araddr_i,
  input wire arvalid_i,
  output wire arready_o,
  // axi4-lite read data
  output wire [31:0] rdata_o,
  output wire [1:0] rresp_o,
  output wire rvalid_o,
  input wire rready_i,
  // pwm pins and interrupt
  output wire [4:0] channel_output_o,
  output wire irq_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function dec_ok;
    input [7:0] addr;
    begin
      dec_ok = (addr[`P5_ADDR_HOLE] == 1'b0) &&
        (addr[`P5_ADDR_IDX] <= `P5_IDX_ICLR);
    end
  endfunction

  // low/high byte registers pair up from index 1; idx 1..14 only
  function [2:0] pair_of;
    input [4:0] idx;
    reg [4:0] tmp;
    begin
      tmp = idx - `P5_IDX_PER_LO;
      pair_of = tmp[3:1];
    end
  endfunction

  function is_pair;
    input [4:0] idx;
    begin
      is_pair = (idx >= `P5_IDX_PER_LO) && (idx <= `P5_IDX_DUTY4_HI);
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [7:0] ctrl_ff;
  reg [15:0] period_ff;
  reg [15:0] period_act_ff;
  reg [15:0] cnt_ff;
  reg [15:0] duty_ff [0:`P5_NCH-1];
  reg [7:0] wr_lo_ff [0:`P5_NPAIR-1];
  reg [7:0] rd_lo_ff [0:`P5_NPAIR-1];
  reg [`P5_IRQ_W-1:0] stat_ff;
  reg [`P5_IRQ_W-1:0] ien_ff;
  reg irq_ff;
  reg [7:0] awaddr_ff;
  reg aw_full_ff;
  reg [7:0] wbyte_ff;
  reg wlane_ff;
  reg w_full_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [1:0] rresp_ff;
  reg [7:0] rbyte_ff;
  integer i;
  integer j;

  wire en;
  wire tick;
  wire wrap;
  wire load;
  wire do_wr;
  wire wr_ok;
  wire do_rd;
  wire [4:0] widx;
  wire [4:0] ridx;
  wire [2:0] wpair;
  wire [2:0] rpair;
  wire [15:0] wval;
  wire [4:0] ch_match;
  wire [`P5_IRQ_W-1:0] events;
  reg [15:0] rpair_val;
  reg [7:0] nxt_rbyte;
  reg nxt_rok;

  // ----------------------------------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------------------------------
  assign awready_o = ~aw_full_ff;
  assign wready_o = ~w_full_ff;
  assign bvalid_o = bvalid_ff;
  assign bresp_o = bresp_ff;
  assign arready_o = ~rvalid_ff;
  assign rvalid_o = rvalid_ff;
  assign rresp_o = rresp_ff;
  assign rdata_o = {24'h00_0000, rbyte_ff};

  assign do_wr = aw_full_ff & w_full_ff & ~bvalid_ff;
  // refused writes (unmapped or lane 0 off) must leave every register alone
  assign wr_ok = do_wr & wlane_ff & dec_ok(awaddr_ff);
  assign do_rd = arvalid_i & ~rvalid_ff;
  assign widx = awaddr_ff[`P5_ADDR_IDX];
  assign ridx = araddr_i[`P5_ADDR_IDX];
  assign wpair = pair_of(widx);
  assign rpair = pair_of(ridx);
  assign wval = {wbyte_ff, wr_lo_ff[wpair]};

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      awaddr_ff <= `P5_RST_BYTE;
      aw_full_ff <= 1'b0;
      wbyte_ff <= `P5_RST_BYTE;
      wlane_ff <= 1'b0;
      w_full_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `P5_RESP_OKAY;
    end else begin
      if (awvalid_i && !aw_full_ff) begin
        awaddr_ff <= awaddr_i;
        aw_full_ff <= 1'b1;
      end else if (do_wr) begin
        aw_full_ff <= 1'b0;
      end
      if (wvalid_i && !w_full_ff) begin
        wbyte_ff <= wdata_i[7:0];
        wlane_ff <= wstrb_i[0];
        w_full_ff <= 1'b1;
      end else if (do_wr) begin
        w_full_ff <= 1'b0;
      end
      if (do_wr) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= dec_ok(awaddr_ff) ? `P5_RESP_OKAY : `P5_RESP_SLVERR;
      end else if (bready_i) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always @* begin
    case (rpair)
      `P5_PAIR_PER: rpair_val = period_ff;
      `P5_PAIR_CNT: rpair_val = cnt_ff;
      default: rpair_val = duty_ff[rpair - `P5_PAIR_DUTY0];
    endcase
  end

  always @* begin
    nxt_rbyte = `P5_RST_BYTE;
    nxt_rok = dec_ok(araddr_i);
    if (!nxt_rok) begin
      nxt_rbyte = `P5_RST_BYTE;
    end else if (ridx == `P5_IDX_CTRL) begin
      nxt_rbyte = ctrl_ff & `P5_CTRL_MASK;
    end else if (ridx == `P5_IDX_STAT) begin
      nxt_rbyte = {2'h0, stat_ff};
    end else if (ridx == `P5_IDX_IEN) begin
      nxt_rbyte = {2'h0, ien_ff};
    end else if (ridx == `P5_IDX_ICLR) begin
      nxt_rbyte = `P5_RST_BYTE;
    end else if (ridx[0]) begin
      nxt_rbyte = rd_lo_ff[rpair];
    end else begin
      nxt_rbyte = rpair_val[15:8];
    end
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= `P5_RESP_OKAY;
      rbyte_ff <= `P5_RST_BYTE;
    end else if (do_rd) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= nxt_rok ? `P5_RESP_OKAY : `P5_RESP_SLVERR;
      rbyte_ff <= nxt_rbyte;
    end else if (rready_i) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // byte pair staging
  // ----------------------------------------------------------------
  // one stage per pair so interleaved pairs do not corrupt each other
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < `P5_NPAIR; i = i + 1) begin
        wr_lo_ff[i] <= `P5_RST_BYTE;
        rd_lo_ff[i] <= `P5_RST_BYTE;
      end
    end else begin
      if (wr_ok && is_pair(widx) && widx[0]) begin
        wr_lo_ff[wpair] <= wbyte_ff;
      end
      if (do_rd && nxt_rok && is_pair(ridx) && !ridx[0]) begin
        rd_lo_ff[rpair] <= rpair_val[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // control, period and duty registers
  // ----------------------------------------------------------------
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= `P5_RST_BYTE;
      period_ff <= `P5_RST_WORD;
      ien_ff <= `P5_RST_IRQ;
      for (j = 0; j < `P5_NCH; j = j + 1) begin
        duty_ff[j] <= `P5_RST_WORD;
      end
    end else if (wr_ok) begin
      if (widx == `P5_IDX_CTRL) begin
        ctrl_ff <= wbyte_ff & `P5_CTRL_MASK;
      end
      if (widx == `P5_IDX_IEN) begin
        ien_ff <= wbyte_ff[`P5_IRQ_W-1:0];
      end
      if (widx == `P5_IDX_PER_HI) begin
        period_ff <= wval;
      end
      if (is_pair(widx) && !widx[0] && wpair >= `P5_PAIR_DUTY0) begin
        duty_ff[wpair - `P5_PAIR_DUTY0] <= wval;
      end
    end
  end

  // ----------------------------------------------------------------
  // shared counter
  // ----------------------------------------------------------------
  // enable bit
  assign en = ctrl_ff[`P5_CTRL_EN];
  p5pwm_prescale p5pwm_prescale_inst (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .run_i(en),
    .sel_i(ctrl_ff[`P5_CTRL_PSC]),
    .tick_o(tick)
  );

  assign wrap = tick & (cnt_ff == period_act_ff);
  // while stopped the active copies follow software directly
  assign load = wrap | ~en;

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= `P5_RST_WORD;
      period_act_ff <= `P5_RST_WORD;
    end else begin
      if (load) begin
        period_act_ff <= period_ff;
      end
      if (wr_ok && widx == `P5_IDX_CNT_HI) begin
        cnt_ff <= wval;
      end else if (wrap) begin
        cnt_ff <= `P5_RST_WORD;
      end else if (tick) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `P5_NCH; g = g + 1) begin : g_ch
      p5pwm_chan p5pwm_chan_inst (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .en_i(en),
        .tick_i(tick),
        .load_i(load),
        .cnt_i(cnt_ff),
        .duty_i(duty_ff[g]),
        .out_o(channel_output_o[g]),
        .match_o(ch_match[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  // period flag in bit 0, channel match flags above it
  assign events = {ch_match, wrap};

  // a new event beats a clear in the same cycle
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_ff <= `P5_RST_IRQ;
      irq_ff <= 1'b0;
    end else begin
      if (wr_ok && widx == `P5_IDX_ICLR) begin
        stat_ff <= (stat_ff & ~wbyte_ff[`P5_IRQ_W-1:0]) | events;
      end else begin
        stat_ff <= stat_ff | events;
      end
      irq_ff <= |(stat_ff & ien_ff);
    end
  end

  assign irq_o = irq_ff;
endmodule

//--- rtl/p5pwm_defs.vh
// constants for the five channel 16-bit pwm block
`ifndef P5PWM_DEFS_VH
`define P5PWM_DEFS_VH
// ----------------------------------------------------------------
// register word indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define P5_IDX_CTRL 5'h00
`define P5_IDX_PER_LO 5'h01
`define P5_IDX_PER_HI 5'h02
`define P5_IDX_CNT_LO 5'h03
`define P5_IDX_CNT_HI 5'h04
`define P5_IDX_DUTY0_LO 5'h05
`define P5_IDX_DUTY4_HI 5'h0e
`define P5_IDX_STAT 5'h0f
`define P5_IDX_IEN 5'h10
`define P5_IDX_ICLR 5'h11
`define P5_ADDR_HOLE 7
`define P5_ADDR_IDX 6:2
// ----------------------------------------------------------------
// byte pairs
// ----------------------------------------------------------------
`define P5_PAIR_PER 3'h0
`define P5_PAIR_CNT 3'h1
`define P5_PAIR_DUTY0 3'h2
`define P5_NPAIR 7
`define P5_NCH 5
// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define P5_CTRL_EN 7
`define P5_CTRL_PSC 2:0
`define P5_CTRL_MASK 8'h87
`define P5_IRQ_W 6
`define P5_IRQ_PER 0
`define P5_IRQ_DUTY0 1
// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define P5_RST_BYTE 8'h00
`define P5_RST_WORD 16'h0000
`define P5_RST_IRQ 6'h00
`define P5_RST_DIV 7'h00
`define P5_DIV_ONES 7'h7f
`define P5_RESP_OKAY 2'h0
`define P5_RESP_SLVERR 2'h2
`endif

//--- rtl/p5pwm_prescale.v
// prescaler making the pwm count enable from the system clock
`timescale 1ns/10ps
`include "p5pwm_defs.vh"
module p5pwm_prescale (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // control
  input wire run_i,
  input wire [2:0] sel_i,
  // enable pulse
  output wire tick_o
);
  reg [6:0] div_ff;
  wire [6:0] mask;

  // divide by two to the power of sel: low sel bits of div all ones
  assign mask = ~(`P5_DIV_ONES << sel_i);
  assign tick_o = run_i & ((div_ff & mask) == mask);

  // divider restarts when stopped so the first period is full length
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff <= `P5_RST_DIV;
    end else if (!run_i) begin
      div_ff <= `P5_RST_DIV;
    end else begin
      div_ff <= div_ff + 7'h01;
    end
  end
endmodule

//--- rtl/p5pwm_chan.v
// one duty channel: active duty copy, output and match pulse
`timescale 1ns/10ps
`include "p5pwm_defs.vh"
module p5pwm_chan (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // timing
  input wire en_i,
  input wire tick_i,
  input wire load_i,
  input wire [15:0] cnt_i,
  // programmed duty
  input wire [15:0] duty_i,
  // results
  output wire out_o,
  output wire match_o
);
  reg [15:0] duty_act_ff;
  reg out_ff;
  reg match_ff;

  assign out_o = out_ff;
  assign match_o = match_ff;

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      duty_act_ff <= `P5_RST_WORD;
      out_ff <= 1'b0;
      match_ff <= 1'b0;
    end else begin
      if (load_i) begin
        duty_act_ff <= duty_i;
      end
      out_ff <= en_i & (cnt_i < duty_act_ff);
      match_ff <= en_i & tick_i & (cnt_i == duty_act_ff);
    end
  end
endmodule

//--- bench/p5pwm_load.sv
// load model on the pwm pins: counts high samples on every pin and pulses on pin 0
`timescale 1ns/10ps
module p5pwm_load (
  // clock
  input wire mclk_i,
  // measuring window
  input wire gate_i,
  // pwm pins
  input wire [4:0] ch_i,
  // results
  output logic [4:0][15:0] hi_o,
  output logic [15:0] rise_o
);
  logic gate_ff = 1'b0;
  logic prev_ff = 1'b0;
  // counts restart on the first sample of a window and hold after it
  always @(posedge mclk_i) begin
    gate_ff <= gate_i;
    prev_ff <= ch_i[0];
    for (int k = 0; k < 5; k++) begin
      if (gate_i) begin
        hi_o[k] <= (gate_ff ? hi_o[k] : 16'h0000) + ch_i[k];
      end
    end
    if (gate_i) begin
      rise_o <= (gate_ff ? rise_o : 16'h0000) + (ch_i[0] & ~prev_ff);
    end
  end
endmodule

//--- bench/p5pwm_chk.sv
// bus and reset assertions on the pwm block ports
`timescale 1ns/10ps
`include "p5pwm_defs.vh"
module p5pwm_chk (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // write side
  input wire awvalid_i,
  input wire awready_o,
  input wire wvalid_i,
  input wire wready_o,
  input wire bvalid_o,
  input wire bready_i,
  // read side
  input wire [7:0] araddr_i,
  input wire arvalid_i,
  input wire arready_o,
  input wire [31:0] rdata_o,
  input wire [1:0] rresp_o,
  input wire rvalid_o,
  input wire rready_i
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wr_take;
    awvalid_i && awready_o && wvalid_i && wready_o;
  endsequence
  sequence s_rd_take;
    arvalid_i && arready_o;
  endsequence
  chk_wr_cycle: assert property (
    s_wr_take |=> !awready_o && !wready_o ##1 bvalid_o)
    else $error("write not answered in two cycles");
  chk_rd_answer: assert property (
    s_rd_take |=> rvalid_o) else $error("read not answered");
  chk_rd_unmapped: assert property (
    s_rd_take ##0 araddr_i[7] |=>
    rresp_o == `P5_RESP_SLVERR && rdata_o == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_rd_upper: assert property (
    rvalid_o |-> rdata_o[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  chk_b_clear: assert property (
    bvalid_o && bready_i |=> !bvalid_o) else $error("bvalid stuck");
  chk_r_clear: assert property (
    rvalid_o && rready_i |=> !rvalid_o) else $error("rvalid stuck");
  chk_ar_busy: assert property (
    rvalid_o |-> !arready_o) else $error("read taken while busy");
  chk_slots_free: assert property (
    $rose(bvalid_o) |-> awready_o && wready_o)
    else $error("write slots not freed");
  chk_rd_mapped: assert property (
    s_rd_take ##0 (!araddr_i[`P5_ADDR_HOLE] &&
    araddr_i[`P5_ADDR_IDX] <= `P5_IDX_ICLR) |=>
    rresp_o == `P5_RESP_OKAY) else $error("mapped read refused");
  chk_reset_idle: assert property (
    $rose(rst_n_i) |-> !bvalid_o && !rvalid_o && arready_o)
    else $error("bus not idle after reset");
endmodule
bind p5pwm_top p5pwm_chk p5pwm_chk_inst (.mclk_i, .rst_n_i, .awvalid_i,
  .awready_o, .wvalid_i, .wready_o, .bvalid_o, .bready_i, .araddr_i,
  .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i);

//--- bench/p5pwm_top_tb.sv
// self-checking bench for the five channel pwm block
`timescale 1ns/10ps
`include "p5pwm_defs.vh"
module p5pwm_top_tb;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr_i = 8'h00;
  logic [7:0] araddr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic [3:0] wstrb_i = 4'hf;
  logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0;
  logic arvalid_i = 1'b0, rready_i = 1'b0, gate = 1'b0;
  wire awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
  wire [1:0] bresp_o, rresp_o;
  wire [31:0] rdata_o;
  wire [4:0] channel_output_o;
  wire [4:0][15:0] hi;
  wire [15:0] rise;
  int mismatches = 0, n_checks = 0, cyc = 0, i, p;
  logic [31:0] d;
  logic [1:0] r;
  localparam logic [4:0][15:0] DUTY = {16'h0003, 16'h0001, 16'h0005,
    16'h0000, 16'h0002};
  // duty beyond the period of four steps keeps the pin high throughout
  localparam logic [4:0][15:0] CLIP = {16'h0003, 16'h0001, 16'h0004,
    16'h0000, 16'h0002};

  p5pwm_top p5pwm_top_inst (.mclk_i, .rst_n_i, .awaddr_i, .awvalid_i,
    .awready_o, .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o,
    .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o,
    .rresp_o, .rvalid_o, .rready_i, .channel_output_o, .irq_o);
  p5pwm_load p5pwm_load_inst (.mclk_i, .gate_i(gate),
    .ch_i(channel_output_o), .hi_o(hi), .rise_o(rise));

  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  function automatic [7:0] ad(input [4:0] x);
    ad = {1'b0, x, 2'b00};
  endfunction
  task automatic chk(input [31:0] g, input [31:0] e);
    n_checks = n_checks + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input [4:0] x, input [7:0] v);
    bit aw, w;
    @(posedge mclk_i);
    aw = 0;
    w = 0;
    awaddr_i <= ad(x);
    wdata_i <= {24'h00_0000, v};
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    while (!(aw && w)) begin
      @(posedge mclk_i);
      if (!aw && awready_o === 1'b1) begin
        aw = 1;
        awvalid_i <= 1'b0;
      end
      if (!w && wready_o === 1'b1) begin
        w = 1;
        wvalid_i <= 1'b0;
      end
    end
    do @(posedge mclk_i); while (bvalid_o !== 1'b1);
    r = bresp_o;
    bready_i <= 1'b0;
  endtask
  task automatic rd(input [7:0] a);
    @(posedge mclk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do @(posedge mclk_i); while (arready_o !== 1'b1);
    arvalid_i <= 1'b0;
    do @(posedge mclk_i); while (rvalid_o !== 1'b1);
    d = rdata_o;
    r = rresp_o;
    rready_i <= 1'b0;
  endtask
  task automatic wr16(input [4:0] x, input [15:0] v);
    wr(x, v[7:0]);
    wr(x + 5'h01, v[15:8]);
  endtask
  task automatic rd16(input [4:0] x, input [15:0] e);
    rd(ad(x + 5'h01));
    chk(d, {24'h00_0000, e[15:8]});
    rd(ad(x));
    chk(d, {24'h00_0000, e[7:0]});
  endtask
  task automatic measure(input int n);
    gate <= 1'b1;
    repeat (n) @(posedge mclk_i);
    gate <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (i = 0; i <= 16; i++) begin
      rd(ad(5'(i)));
      chk(d, 32'h0000_0000);
    end
    wr(`P5_IDX_CTRL, 8'h7f);
    chk(r, `P5_RESP_OKAY);
    rd(ad(`P5_IDX_CTRL));
    chk(d, 32'h0000_0007);
    chk(r, `P5_RESP_OKAY);
    // a write with byte lane 0 off leaves the register alone
    wstrb_i <= 4'he;
    wr(`P5_IDX_CTRL, 8'h00);
    wstrb_i <= 4'hf;
    rd(ad(`P5_IDX_CTRL));
    chk(d, 32'h0000_0007);
    rd(8'h80);
    chk(r, `P5_RESP_SLVERR);
    wr(5'h12, 8'hff);
    chk(r, `P5_RESP_SLVERR);
    wr16(`P5_IDX_PER_LO, 16'h0003);
    for (i = 0; i < 5; i++) begin
      wr16(5'(`P5_IDX_DUTY0_LO + 2 * i), DUTY[i]);
    end
    rd16(`P5_IDX_PER_LO, 16'h0003);
    // every divider code, pins measured over four whole periods
    for (p = 0; p < 8; p++) begin
      wr(`P5_IDX_CTRL, 8'h80 | 8'(p));
      repeat (8 << p) @(posedge mclk_i);
      measure(16 << p);
      for (i = 0; i < 5; i++) begin
        chk(hi[i], CLIP[i] << (p + 2));
      end
      chk(rise, 32'h0000_0004);
    end
    wr(`P5_IDX_ICLR, 8'h3f);
    repeat (600) @(posedge mclk_i);
    rd(ad(`P5_IDX_STAT));
    chk(d, 32'h0000_0037);
    chk(irq_o, 1'b0);
    wr(`P5_IDX_IEN, 8'h01);
    repeat (2) @(posedge mclk_i);
    chk(irq_o, 1'b1);
    wr(`P5_IDX_IEN, 8'h00);
    repeat (2) @(posedge mclk_i);
    chk(irq_o, 1'b0);
    wr(`P5_IDX_IEN, 8'h01);
    wr(`P5_IDX_CTRL, 8'h00);
    wr(`P5_IDX_ICLR, 8'h3f);
    repeat (2) @(posedge mclk_i);
    chk(irq_o, 1'b0);
    chk(channel_output_o, 5'h00);
    rd(ad(`P5_IDX_STAT));
    chk(d, 32'h0000_0000);
    // counter holds while stopped, so the written value reads back
    wr16(`P5_IDX_CNT_LO, 16'h1234);
    rd16(`P5_IDX_CNT_LO, 16'h1234);
    end_of_test();
  end
endmodule
